// ---- bench/ssp_slave.sv ----
// serial slave model that faces the port on its far side
module ssp_slave (
    input wire logic sclk_i,
    input wire logic fss_b_i,
    input wire logic txd_i,
    input wire logic cpha_i,
    input wire logic cmd_i,
    input wire logic [4:0] bits_i,
    input wire logic [15:0] reply_i,
    output logic rxd_o,
    output logic [15:0] got_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv = 1'b0; // bit shown to the master
    logic en = 1'b0; // line driven while set
    int idx; // next spi reply bit
    int rs; // command bits latched
    int fl; // falls after the command
    // a released line shows the inverse, so a stale bit never passes
    assign rxd_o = en ? drv : ~drv;
    // ****************************************************************
    // select edges
    // ****************************************************************
    always @(negedge fss_b_i) begin
        idx = cpha_i ? 0 : 1;
        rs = 0;
        fl = 0;
        en = !cmd_i && !cpha_i;
        drv = reply_i[bits_i-1]; // data at select fall
    end
    always @(posedge fss_b_i) en = 1'b0;
    // ****************************************************************
    // clock edges
    // ****************************************************************
    always @(posedge sclk_i) begin
        if (!fss_b_i && cmd_i && rs < 8) begin
            got_o = {got_o[14:0], txd_i}; // latch command on rise
            rs++;
        end else if (!fss_b_i && cmd_i && fl == bits_i + 1) begin
            rs = 0; // reply done, next command may follow
            fl = 0;
        end else if (!fss_b_i && cpha_i && !cmd_i) begin
            got_o = {got_o[14:0], txd_i}; // capture on rise
        end else if (!fss_b_i && !cmd_i && idx < bits_i) begin
            drv = reply_i[bits_i-1-idx]; // change on rise
            idx++;
        end
    end
    always @(negedge sclk_i) begin
        if (!fss_b_i && cmd_i && rs < 8) begin
            en = 1'b0; // let go after the reply lsb
        end else if (!fss_b_i && cmd_i) begin
            fl++;
            en = fl > 1; // one clock wait, then reply on falls
            if (fl > 1) drv = reply_i[bits_i+1-fl];
        end else if (!fss_b_i && cpha_i) begin
            drv = reply_i[bits_i-1-idx]; // drive on fall
            en = 1'b1;
            idx = (idx == bits_i - 1) ? 0 : idx + 1;
        end else if (!fss_b_i) begin
            got_o = {got_o[14:0], txd_i}; // capture on fall
        end
    end
endmodule : ssp_slave

// ---- bench/tb_top.sv ----
// top testbench: drives the port, slave model on the far side, checks pins and words
module tb_top;
    timeunit 1ns;
    timeprecision 100ps; // half periods of 12.5 ns must not round
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_b = 1'b0;
    logic en = 1'b0, ms = 1'b1, pol = 1'b1, pha = 1'b0, cmd = 1'b0; // settings
    logic [3:0] size = 4'h7;
    logic tv = 1'b0;
    logic [15:0] td = 16'h0000;
    logic [15:0] rep = 16'h0000; // slave reply word
    logic tr, rv, sc, sc_oe, fs_b, txd, txd_oe, rxd;
    logic [15:0] rd, got;
    logic [15:0] rxq[$]; // words handed out by the port
    int error_cnt = 0;
    int tests_run = 0;
    int hl = 0; // link halves seen with select low
    int len, first, nfr; // last low length, first clock move, frames
    logic oe0, bit0, bit1; // pad enable at h0, data at h0 and h1
    // ****************************************************************
    // clocks, design and slave
    // ****************************************************************
    initial forever #12.5 clk = ~clk;
    // link clock: unrelated phase, one rising edge per half serial period
    initial begin
        #3;
        forever #6 lclk = ~lclk;
    end
    ssp_top u_ssp_top (
        .clk_i(clk), .rst_b_i(rst_b), .link_clk_i(lclk), .enable_i(en), .master_i(ms),
        .clock_polarity_bit_i(pol), .clock_phase_bit_i(pha), .cmd_resp_mode_i(cmd),
        .word_size_i(size), .tx_valid_i(tv), .tx_data_i(td), .tx_ready_o(tr),
        .rx_valid_o(rv), .rx_data_o(rd), .serial_clock_pin_o(sc),
        .serial_clock_pin_oe_o(sc_oe), .frame_select_pin_b_o(fs_b),
        .transmit_data_pin_o(txd), .transmit_data_pin_oe_o(txd_oe),
        .receive_data_pin_i(rxd)
    );
    ssp_slave u_ssp_slave (
        .sclk_i(sc), .fss_b_i(fs_b), .txd_i(txd), .cpha_i(pha), .cmd_i(cmd),
        .bits_i({1'b0, size} + 5'h01), .reply_i(rep), .rxd_o(rxd), .got_o(got)
    );
    // pins sampled mid link period, where they are settled
    always @(negedge lclk) begin
        if (fs_b === 1'b0) begin
            if (hl == 0) oe0 = txd_oe;
            if (hl == 0) bit0 = txd;
            if (hl == 1) bit1 = txd;
            if (first == 0 && sc !== (pol & ~cmd)) first = hl;
            hl++;
        end else if (hl != 0) begin
            len = hl;
            nfr++;
            hl = 0;
        end
    end
    // receive pulse taken mid cycle, where it is settled
    always @(negedge clk) if (rv === 1'b1) rxq.push_back(rd);
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic timeout();
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        wrap_up();
    endtask : timeout
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // settings move only while the port is off
    task automatic setup(input logic p, input logic c, input int n);
        @(negedge clk);
        en = 1'b0;
        cyc(8);
        pha = p;
        cmd = c;
        size = 4'(n - 1);
        cyc(8);
        en = 1'b1;
        cyc(8);
    endtask : setup
    // offer one word and hold it until the port takes it
    task automatic send(input logic [15:0] w);
        int k;
        @(negedge clk);
        td = w;
        tv = 1'b1;
        for (k = 0; k < 400 && tr !== 1'b1; k++) @(negedge clk);
        if (k == 400) timeout();
        @(negedge clk);
        tv = 1'b0;
        check(tr, 1'b0); // word in flight, ready must drop
    endtask : send
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_idle();
        setup(1'b0, 1'b0, 8);
        check({sc, sc_oe, fs_b, txd, txd_oe}, 5'b11100); // high polarity idle
        en = 1'b0;
        cyc(4);
        ms = 1'b0;
        cyc(12);
        check(sc_oe, 1'b0); // clock pad off as slave
        ms = 1'b1;
        cyc(12);
    endtask : t_idle
    // one or two words, then frame shape, words both ways and idle levels
    task automatic run(input logic p, input logic c, input int n, input bit two,
                       input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] r);
        logic [15:0] m, mt, ww;
        logic [31:0] gm;
        int tn, nw, k;
        m = 16'((32'h1 << n) - 1);
        mt = c ? 16'h00ff : m;
        tn = c ? 8 : n;
        nw = two ? 2 : 1;
        gm = (32'h1 << (two ? 2 * tn : tn)) - 1;
        ww = (two && (p || c)) ? w0 : w1;
        setup(p, c, n);
        rep = r;
        rxq.delete();
        nfr = 0;
        first = 0;
        if (two) send(w0);
        send(w1);
        for (k = 0; k < 2000 && !(rxq.size() == nw && fs_b === 1'b1); k++) @(negedge clk);
        if (k == 2000) timeout();
        cyc(20);
        check(16'(rxq.size()), 16'(nw)); // one received word per word sent
        foreach (rxq[i]) check(rxq[i], r & m); // reply msb first
        check(got & 16'(gm), 16'(((two ? w0 & mt : 16'h0) << tn | (w1 & mt)) & gm));
        check(16'(nfr), 16'((two && !p && !c) ? 2 : 1));
        check(16'(len), 16'(c ? (two ? 4 : 2) * (9 + n) + 1 : (two && p ? 4 : 2) * n + 2));
        check(16'(first), 16'((p || c) ? 1 : 2)); // first clock move
        check(oe0, 1'b1); // data pad on at select fall
        check(c ? bit0 : bit1, ww[c ? 7 : n - 1]); // first bit is the msb
        check({sc, fs_b, txd, txd_oe}, {~c, 3'b100}); // idle once drained
    endtask : run
    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        cyc(10);
        t_idle();
        run(1'b0, 1'b0, 8, 1'b1, 16'h00a5, 16'h003c, 16'h00c3);
        run(1'b1, 1'b0, 8, 1'b1, 16'h0096, 16'h0069, 16'h005a);
        run(1'b0, 1'b0, 16, 1'b0, 16'h0000, 16'hbeef, 16'h8001);
        run(1'b1, 1'b0, 4, 1'b0, 16'h0000, 16'h000a, 16'hfff5);
        run(1'b0, 1'b1, 4, 1'b0, 16'h0000, 16'h00b7, 16'h0009);
        run(1'b0, 1'b1, 16, 1'b1, 16'h0081, 16'h007e, 16'ha55a);
        wrap_up();
    end
endmodule : tb_top

// ---- src/ssp_defines.svh ----
// constants of the sync serial port: widths, idle levels, reset values and frame step counts
//
// What this block does
// - idle high clock, select high, data low
// - clock pad enabled as master, off as slave
// - frame starts with select low, data pad on
// - phase zero: data half later, clock after
// - phase zero single word: select up after period
// - phase zero runs: select pulses between words
// - phase one: first edge falls with data
// - phase one runs: select low until last word
// - command/response: 8 bits out, reply in
// - command/response idle: clock low, select high
// - command written starts frame, MSB at fall
// - receive line ignored during command, latch rising
// - single reply: select up, word to receive
// - continuous replies: select low, next command follows
// - words 1 to 16 bits, MSB first
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ****************************************************************
// word and step widths
// ****************************************************************
`define SSP_WORD_W 16
`define SSP_STEP_W 6
`define SSP_WORD_FULL 6'h10
`define SSP_CMD_BITS 8

// ****************************************************************
// command/response step counts, in link clock halves, and clock polarity
// ****************************************************************
`define SSP_MW_OVERHEAD 6'h12
`define SSP_MW_FIRST_CAP 6'h13
`define SSP_MW_CPOL 1'b0

// ****************************************************************
// idle line levels and reset values
// ****************************************************************
`define SSP_IDLE_FSS_B 1'b1
`define SSP_IDLE_TXD 1'b0
`define SSP_RST_WORD 16'h0000
`define SSP_RST_STEP 6'h00

`endif

// ---- src/ssp_pkg.sv ----
// types shared by the sync serial port files
package ssp_pkg;
    // ****************************************************************
    // configuration carried across into the link domain
    // ****************************************************************
    typedef struct packed {
        logic enable;    // port enable
        logic master;    // master when set
        logic cpol;      // clock polarity bit
        logic cpha;      // clock phase bit
        logic mw;        // command/response format
        logic [3:0] size; // word bits minus one
    } ssp_cfg_t;

    // pin levels driven toward the slave
    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic fss_b;
        logic txd;
        logic txd_oe;
    } ssp_pins_t;

    // frame engine states
    typedef enum logic {ST_IDLE, ST_RUN} ssp_state_t;
endpackage : ssp_pkg

// ---- src/ssp_sync2.sv ----
// two flip-flop synchroniser, also used to release resets
module ssp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta; // first stage, read only by the second
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // ****************************************************************
    // stage shifting
    // ****************************************************************
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    // both stages clear on reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end
endmodule : ssp_sync2

// ---- src/ssp_top.sv ----
// sync serial port master: system-side word handshake and link-side frame engine
`include "ssp_defines.svh"
module ssp_top import ssp_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic enable_i,
    input wire logic master_i,
    input wire logic clock_polarity_bit_i,
    input wire logic clock_phase_bit_i,
    input wire logic cmd_resp_mode_i,
    input wire logic [3:0] word_size_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [15:0] rx_data_o,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_o,
    output logic frame_select_pin_b_o,
    output logic transmit_data_pin_o,
    output logic transmit_data_pin_oe_o,
    input wire logic receive_data_pin_i
);
    // ****************************************************************
    // reset release in both domains
    // ****************************************************************
    logic sys_rst_b;  // system-domain reset copy
    logic link_rst_b; // link-domain reset copy

    ssp_sync2 #(.W(1)) u_sys_rst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .d_i(1'b1), .q_o(sys_rst_b)
    );
    ssp_sync2 #(.W(1)) u_link_rst (
        .clk_i(link_clk_i), .rst_b_i(rst_b_i), .d_i(1'b1), .q_o(link_rst_b)
    );

    // ****************************************************************
    // system side: transmit word hand-off and receive word pickup
    // ****************************************************************
    logic [15:0] tx_word;  // held until the link side acknowledges
    logic tx_req;          // toggles once per offered word
    logic tx_ack_s;        // link acknowledge, synchronised
    logic rx_req_s;        // link receive toggle, synchronised
    logic rx_seen;         // last receive toggle consumed
    logic [15:0] rx_word_l; // link-held received word
    logic rx_req_l;
    logic tx_ack_l;
    logic [15:0] next_tx_word;
    logic next_tx_req;
    logic next_rx_seen;
    logic next_rx_valid;
    logic [15:0] next_rx_data;

    ssp_sync2 #(.W(2)) u_sys_sync (
        .clk_i(clk_i), .rst_b_i(sys_rst_b),
        .d_i({tx_ack_l, rx_req_l}), .q_o({tx_ack_s, rx_req_s})
    );

    // one word in flight: ready only when the last offer was taken
    assign tx_ready_o = (tx_req == tx_ack_s);

    // next values of the system side
    always_comb begin
        next_tx_word = tx_word;
        next_tx_req = tx_req;
        next_rx_seen = rx_seen;
        next_rx_valid = 1'b0;
        next_rx_data = rx_data_o;
        if (tx_valid_i && tx_ready_o) begin
            next_tx_word = tx_data_i;
            next_tx_req = ~tx_req;
        end
        // word is stable in the link register since its toggle was raised
        if (rx_req_s != rx_seen) begin
            next_rx_seen = rx_req_s;
            next_rx_valid = 1'b1;
            next_rx_data = rx_word_l;
        end
    end

    always_ff @(posedge clk_i or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            tx_word <= `SSP_RST_WORD;
            tx_req <= 1'b0;
            rx_seen <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= `SSP_RST_WORD;
        end else begin
            tx_word <= next_tx_word;
            tx_req <= next_tx_req;
            rx_seen <= next_rx_seen;
            rx_valid_o <= next_rx_valid;
            rx_data_o <= next_rx_data;
        end
    end

    // ****************************************************************
    // link side: inputs crossed in
    // ****************************************************************
    ssp_cfg_t cfg_s;  // settings, static while enabled
    ssp_cfg_t cfg_l;  // synchronised settings
    logic tx_req_l;   // synchronised transmit toggle
    logic rxd_l;      // synchronised receive pin

    assign cfg_s = '{enable: enable_i, master: master_i, cpol: clock_polarity_bit_i,
                     cpha: clock_phase_bit_i, mw: cmd_resp_mode_i, size: word_size_i};

    // receive pin is retimed too; the capture strobe is delayed to match
    ssp_sync2 #(.W(11)) u_link_sync (
        .clk_i(link_clk_i), .rst_b_i(link_rst_b),
        .d_i({cfg_s, tx_req, receive_data_pin_i}), .q_o({cfg_l, tx_req_l, rxd_l})
    );

    // ****************************************************************
    // frame engine: one link clock edge is half a serial clock period
    // ****************************************************************
    ssp_state_t st;
    ssp_state_t next_st;
    logic [5:0] step;       // half period index inside a word
    logic [5:0] next_step;
    logic [15:0] tx_sh;     // transmit shifter, MSB goes out
    logic [15:0] next_tx_sh;
    logic next_tx_ack;
    ssp_pins_t pins;
    ssp_pins_t next_pins;
    logic [5:0] nbits;      // programmed word length
    logic [5:0] two_n;
    logic [5:0] two_l;      // halves in one command/response word
    logic avail;            // a word waits on the system side
    logic load;
    logic shift_edge;
    logic cap;              // capture edge on this transition
    logic last;             // capture of the word's final bit
    logic eff_cpol;

    assign nbits = {2'b00, cfg_l.size} + 6'h01;
    assign two_n = {nbits[4:0], 1'b0};
    assign two_l = two_n + `SSP_MW_OVERHEAD;
    assign avail = (tx_req_l != tx_ack_l);
    assign eff_cpol = cfg_l.mw ? `SSP_MW_CPOL : cfg_l.cpol;

    // sequencing, shifting and pin levels
    always_comb begin
        next_st = st;
        next_step = step;
        next_tx_sh = tx_sh;
        next_tx_ack = tx_ack_l;
        load = 1'b0;
        case (st)
            ST_IDLE: begin
                // start only as enabled master with a word waiting
                if (cfg_l.enable && cfg_l.master && avail) begin
                    next_st = ST_RUN;
                    next_step = `SSP_RST_STEP;
                    load = 1'b1;
                end
            end
            ST_RUN: begin
                if (cfg_l.mw) begin
                    // next command follows the reply LSB under low select
                    if (step == two_l - 6'h01 && avail && cfg_l.enable) begin
                        next_step = `SSP_RST_STEP;
                        load = 1'b1;
                    end else if (step == two_l) begin
                        next_st = ST_IDLE;
                    end else begin
                        next_step = step + 6'h01;
                    end
                end else begin
                    // phase one runs on without releasing select
                    if (step == two_n && cfg_l.cpha && avail && cfg_l.enable) begin
                        next_step = 6'h01;
                        load = 1'b1;
                    end else if (step == two_n + 6'h01) begin
                        next_st = ST_IDLE;
                    end else begin
                        next_step = step + 6'h01;
                    end
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
        if (load) begin
            next_tx_ack = ~tx_ack_l;
        end
        // transmit data changes on the non-capture edge
        if (cfg_l.mw) begin
            shift_edge = !next_step[0] && (next_step != 6'h00);
        end else begin
            shift_edge = next_step[0] && (next_step >= 6'h03);
        end
        if (load) begin
            // left-justify so the MSB leaves first
            if (cfg_l.mw) begin
                next_tx_sh = {tx_word[7:0], 8'h00};
            end else begin
                next_tx_sh = tx_word << (`SSP_WORD_FULL - nbits);
            end
        end else if (next_st == ST_RUN && shift_edge) begin
            next_tx_sh = {tx_sh[14:0], 1'b0};
        end
        // capture edges; command bits of the other format are never sampled
        if (cfg_l.mw) begin
            cap = next_step[0] && next_step >= `SSP_MW_FIRST_CAP
                  && next_step <= two_l - 6'h01;
            last = next_step == two_l - 6'h01;
        end else begin
            cap = !next_step[0] && next_step >= 6'h02 && next_step <= two_n;
            last = next_step == two_n;
        end
        cap = cap && (next_st == ST_RUN);
        last = last && cap;
        // pin levels follow the new step
        next_pins.sclk_oe = cfg_l.master;
        if (next_st == ST_IDLE) begin
            next_pins.sclk = eff_cpol;
            next_pins.fss_b = `SSP_IDLE_FSS_B;
            next_pins.txd = `SSP_IDLE_TXD;
            next_pins.txd_oe = 1'b0;
        end else begin
            next_pins.fss_b = 1'b0;
            next_pins.txd_oe = 1'b1;
            // both phases outside command/response hold data off for the first half period
            if (!cfg_l.mw && next_step == 6'h00) begin
                next_pins.txd = `SSP_IDLE_TXD;
            end else begin
                next_pins.txd = next_tx_sh[15];
            end
            if (cfg_l.mw) begin
                next_pins.sclk = next_step[0] && next_step <= two_l - 6'h01;
            end else if (cfg_l.cpha) begin
                next_pins.sclk = cfg_l.cpol ^ (next_step[0] && next_step < two_n);
            end else begin
                next_pins.sclk = cfg_l.cpol
                    ^ (!next_step[0] && next_step >= 6'h02 && next_step <= two_n);
            end
        end
    end

    always_ff @(posedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            st <= ST_IDLE;
            step <= `SSP_RST_STEP;
            tx_sh <= `SSP_RST_WORD;
            tx_ack_l <= 1'b0;
            pins <= '{sclk: 1'b0, sclk_oe: 1'b0, fss_b: 1'b1, txd: 1'b0, txd_oe: 1'b0};
        end else begin
            st <= next_st;
            step <= next_step;
            tx_sh <= next_tx_sh;
            tx_ack_l <= next_tx_ack;
            pins <= next_pins;
        end
    end

    assign serial_clock_pin_o = pins.sclk;
    assign serial_clock_pin_oe_o = pins.sclk_oe;
    assign frame_select_pin_b_o = pins.fss_b;
    assign transmit_data_pin_o = pins.txd;
    assign transmit_data_pin_oe_o = pins.txd_oe;

    // ****************************************************************
    // receive shifter, two halves behind the capture edge
    // ****************************************************************
    logic [1:0] cap_pipe;   // capture strobe waiting for the retimed pin
    logic [1:0] last_pipe;
    logic [15:0] rx_sh;
    logic [1:0] next_cap_pipe;
    logic [1:0] next_last_pipe;
    logic [15:0] next_rx_sh;
    logic [15:0] next_rx_word;
    logic next_rx_req;
    logic [15:0] rx_mask;

    assign rx_mask = 16'hffff >> (`SSP_WORD_FULL - nbits);

    // shift one bit per delayed capture; hand over on the final bit
    always_comb begin
        next_cap_pipe = {cap_pipe[0], cap};
        next_last_pipe = {last_pipe[0], last};
        next_rx_sh = rx_sh;
        next_rx_word = rx_word_l;
        next_rx_req = rx_req_l;
        if (cap_pipe[1]) begin
            next_rx_sh = {rx_sh[14:0], rxd_l};
        end
        // single reply lands as select rises; back-to-back it lands mid-run
        if (cap_pipe[1] && last_pipe[1]) begin
            next_rx_word = next_rx_sh & rx_mask;
            next_rx_req = ~rx_req_l;
        end
    end

    always_ff @(posedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            cap_pipe <= 2'h0;
            last_pipe <= 2'h0;
            rx_sh <= `SSP_RST_WORD;
            rx_word_l <= `SSP_RST_WORD;
            rx_req_l <= 1'b0;
        end else begin
            cap_pipe <= next_cap_pipe;
            last_pipe <= next_last_pipe;
            rx_sh <= next_rx_sh;
            rx_word_l <= next_rx_word;
            rx_req_l <= next_rx_req;
        end
    end

    // ****************************************************************
    // checks on the link side
    // ****************************************************************
    logic [4:0] cap_cnt; // captures seen in the current word

    always_ff @(posedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            cap_cnt <= 5'h00;
        end else if (load) begin
            cap_cnt <= 5'h00;
        end else if (cap) begin
            cap_cnt <= cap_cnt + 5'h01;
        end
    end

    // registered pins lag a settings change by one link edge
    idle_levels_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (st == ST_IDLE) |-> (frame_select_pin_b_o && !transmit_data_pin_o
                             && serial_clock_pin_o == $past(eff_cpol)))
        else $error("idle line levels wrong");

    clock_pad_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        $stable(cfg_l.master) |-> serial_clock_pin_oe_o == cfg_l.master)
        else $error("clock pad enable does not follow master");

    frame_start_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (st == ST_IDLE && next_st == ST_RUN) |=> (!frame_select_pin_b_o
                                                  && transmit_data_pin_oe_o))
        else $error("frame start without select low and data pad");

    phase_zero_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        ($fell(frame_select_pin_b_o) && !cfg_l.mw && !cfg_l.cpha)
        |-> serial_clock_pin_o == cfg_l.cpol ##1 serial_clock_pin_o == cfg_l.cpol
            ##1 serial_clock_pin_o != cfg_l.cpol)
        else $error("phase zero first edge misplaced");

    phase_one_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        ($fell(frame_select_pin_b_o) && !cfg_l.mw && cfg_l.cpha)
        |-> serial_clock_pin_o == cfg_l.cpol ##1 serial_clock_pin_o != cfg_l.cpol)
        else $error("phase one first edge misplaced");

    select_release_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (last && !cfg_l.mw && !cfg_l.cpha) |=> !frame_select_pin_b_o ##1 !frame_select_pin_b_o
            ##1 frame_select_pin_b_o)
        else $error("select not released one period after last capture");

    select_hold_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (last && !cfg_l.mw && cfg_l.cpha) |=> !frame_select_pin_b_o ##1 !frame_select_pin_b_o)
        else $error("phase one select rose at last capture");

    // in phase one a waiting word must run on under the same low select
    run_on_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (last && !cfg_l.mw && cfg_l.cpha && avail && cfg_l.enable)
        |=> !frame_select_pin_b_o ##1 !frame_select_pin_b_o ##1 !frame_select_pin_b_o)
        else $error("phase one select released between words");

    word_bits_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        last |-> ({1'b0, cap_cnt} + 6'h01 == nbits))
        else $error("wrong count of captured bits");

    reply_push_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        ($rose(frame_select_pin_b_o) && cfg_l.mw) |-> $changed(rx_req_l))
        else $error("reply not handed over as select rises");

    clock_quiet_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
        (st == ST_IDLE && $past(st) == ST_IDLE && $past(eff_cpol) == $past(eff_cpol, 2))
        |-> $stable(serial_clock_pin_o))
        else $error("clock toggles while idle");
endmodule : ssp_top
